// ### design/hbp_device.sv
// Purpose: Device end of host bus port with small register file
// Assumes: inputs synchronous to clk
// Notes: registers stand in for the controller's real registers
`include "hbp_params.svh"
`default_nettype none
module hbp_device
   import hbp_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_b, // Async reset
   hbp_if.device bus, // Host pins
   output logic serialTx, // Serial out
   input wire logic serialRx, // Serial in
   output logic [7:0] rxSeen, // Last sampled serial in bits
   output logic inReset, // Pin reset active
   output logic [1:0] modeOut, // Active bus mode
   input wire logic irqRequest // Internal interrupt request
);
   typedef struct packed {
      logic [7:0] [7:0] regs;
      logic [2:0] addr;
      logic [7:0] rdData;
      logic drive;
      logic [7:0] rxBits;
   } hbp_dev_st_t;
   hbp_dev_st_t st_q, st_d;
   hbp_mode_t mode;
   logic [3:0] lvl, rs, fl;
   logic pinReset, csActive, readAct, writeAct, readEnd, writeFall, writeRise, wrDir;
   logic [2:0] curAddr;

   hbp_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .din({bus.csN, bus.readStrobeN, bus.writeStrobeN, bus.addrLatchStrobeN}),
      .level(lvl),
      .rise(rs),
      .fall(fl)
   );

   // ***********************
   // Mode and reset decode
   // ***********************
   always_comb
   begin
      if (bus.muxBusEnable)
         mode = HBP_MUX_BUS;
      else if (bus.busStyleSel)
         mode = HBP_SEP_STROBE;
      else
         mode = HBP_DIR_SELECT;
   end
   assign pinReset = (bus.muxBusEnable || bus.busStyleSel) ? bus.resetPin : ~bus.resetPin;
   assign modeOut = mode;
   assign inReset = pinReset;

   // ***********************
   // Access decode
   // ***********************
   assign csActive = ~lvl[3];
   assign curAddr = (mode == HBP_MUX_BUS) ? st_q.addr : {bus.addr[2:1], bus.addrLatchStrobeN};
   assign wrDir = lvl[1];
   always_comb
   begin
      readAct = 1'b0;
      readEnd = 1'b0;
      writeFall = 1'b0;
      writeRise = 1'b0;
      case (mode)
         HBP_DIR_SELECT:
         begin
            readAct = csActive && wrDir;
            writeRise = rs[3] && !lvl[1];
            readEnd = rs[3];
         end
         default:
         begin
            readAct = csActive && !lvl[2];
            readEnd = rs[2];
            writeFall = csActive && fl[1];
            writeRise = rs[1] && csActive;
         end
      endcase
   end
   assign writeAct = writeFall;

   // ***********************
   // State update
   // ***********************
   always_comb
   begin
      st_d = st_q;
      st_d.rxBits = {st_q.rxBits[6:0], serialRx};
      if (pinReset)
      begin
         st_d = '0;
         st_d.rxBits = st_q.rxBits;
      end
      else
      begin
         if (mode == HBP_MUX_BUS && rs[0] && csActive)
            st_d.addr = bus.dataBus[2:0];
         if (readAct && (!st_q.drive || writeAct))
         begin
            st_d.rdData = st_q.regs[curAddr];
            st_d.drive = 1'b1;
         end
         if (readEnd || !csActive)
            st_d.drive = 1'b0;
         if (writeRise && (mode != HBP_MUX_BUS || lvl[0]))
            st_d.regs[curAddr] = bus.dataBus;
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // ***********************
   // Outputs
   // ***********************
   assign bus.devData = st_q.rdData;
   assign bus.devDataOe = st_q.drive && !pinReset;
   assign serialTx = 1'b1;
   assign rxSeen = st_q.rxBits;
   always_comb
   begin
      bus.irqOut = 1'b0;
      bus.irqOe = 1'b0;
      if (!pinReset)
      begin
         if (mode == HBP_DIR_SELECT)
         begin
            bus.irqOut = 1'b0;
            bus.irqOe = irqRequest;
         end
         else
         begin
            bus.irqOut = irqRequest;
            bus.irqOe = st_q.regs[`HBP_CTRL_REG][`HBP_IRQ_OE_BIT];
         end
      end
   end
endmodule // hbp_device
`default_nettype wire

// ### design/hbp_host.sv
// Purpose: Host end issuing single register accesses
// Assumes: device end on same clock
// Notes: one access per go pulse
`include "hbp_params.svh"
`default_nettype none
module hbp_host
   import hbp_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_b, // Async reset
   hbp_if.host bus, // Device pins
   input wire logic [1:0] modeSel, // Bus mode to use
   input wire logic resetReq, // Pulse device reset
   input wire logic go, // Start access
   input wire logic isWrite, // Write when high
   input wire logic [2:0] regAddr, // Register index
   input wire logic [7:0] wrData, // Write data
   output logic busy, // Access in progress
   output logic done, // Access done pulse
   output logic [7:0] rdData, // Read result
   output logic irqSeen // Interrupt level seen
);
   typedef struct packed {
      hbp_host_state_t st;
      logic [2:0] cnt;
      logic [2:0] rstCnt;
      logic wr;
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] rd;
      logic dn;
   } hbp_host_st_t;
   hbp_host_st_t s_q, s_d;
   logic muxMode, dirMode, rstActive;

   assign muxMode = (modeSel == HBP_MUX_BUS);
   assign dirMode = (modeSel == HBP_DIR_SELECT);
   assign rstActive = (s_q.rstCnt != 3'h0);

   always_comb
   begin
      s_d = s_q;
      s_d.dn = 1'b0;
      if (resetReq)
         s_d.rstCnt = 3'(`HBP_RESET_CYCLES + 1);
      else if (rstActive)
         s_d.rstCnt = s_q.rstCnt - 3'h1;
      case (s_q.st)
         HH_IDLE:
         begin
            if (go && !rstActive)
            begin
               s_d.wr = isWrite;
               s_d.a = regAddr;
               s_d.d = wrData;
               s_d.cnt = 3'h0;
               s_d.st = muxMode ? HH_ADDR : HH_STROBE;
            end
         end
         HH_ADDR:
         begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'(`HBP_STROBE_WAIT))
            begin
               s_d.cnt = 3'h0;
               s_d.st = HH_LATCH;
            end
         end
         HH_LATCH:
         begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'(`HBP_STROBE_WAIT))
            begin
               s_d.cnt = 3'h0;
               s_d.st = HH_STROBE;
            end
         end
         HH_STROBE:
         begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'(`HBP_STROBE_WAIT))
            begin
               s_d.cnt = 3'h0;
               s_d.rd = bus.dataBus;
               s_d.st = HH_RELEASE;
            end
         end
         HH_RELEASE:
         begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'(`HBP_STROBE_WAIT))
               s_d.st = HH_DONE;
         end
         HH_DONE:
         begin
            s_d.dn = 1'b1;
            s_d.st = HH_IDLE;
         end
         default:
            s_d.st = HH_IDLE;
      endcase
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ***********************
   // Pin drive
   // ***********************
   always_comb
   begin
      bus.csN = 1'b1;
      bus.readStrobeN = 1'b1;
      bus.writeStrobeN = 1'b1;
      bus.addrLatchStrobeN = 1'b1;
      bus.addr = s_q.a;
      bus.hostData = s_q.d;
      bus.hostDataOe = 1'b0;
      bus.busStyleSel = (modeSel == HBP_SEP_STROBE);
      bus.muxBusEnable = muxMode;
      bus.resetPin = (bus.busStyleSel || muxMode) ? rstActive : ~rstActive;
      if (!muxMode)
         bus.addrLatchStrobeN = s_q.a[0];
      // Direction mode writes on select rise: direction and data must outlast it
      if (s_q.st == HH_ADDR || s_q.st == HH_LATCH || s_q.st == HH_STROBE || (s_q.st == HH_RELEASE && !dirMode))
         bus.csN = 1'b0;
      if (muxMode && (s_q.st == HH_ADDR || s_q.st == HH_LATCH))
      begin
         bus.hostData = {5'h00, s_q.a};
         bus.hostDataOe = 1'b1;
         bus.addrLatchStrobeN = (s_q.st == HH_ADDR) ? 1'b0 : 1'b1;
      end
      if (s_q.st == HH_STROBE || s_q.st == HH_RELEASE)
      begin
         bus.hostDataOe = s_q.wr;
         if (dirMode)
            bus.writeStrobeN = ~s_q.wr;
         else if (s_q.st == HH_STROBE)
         begin
            bus.readStrobeN = s_q.wr;
            bus.writeStrobeN = ~s_q.wr;
         end
      end
   end
   assign busy = (s_q.st != HH_IDLE);
   assign done = s_q.dn;
   assign rdData = s_q.rd;
   assign irqSeen = bus.irqLine;
endmodule // hbp_host
`default_nettype wire

// ### design/hbp_if.sv
// Purpose: Pins between host and device port
// Assumes: resolves shared data lines and open-drain irq
// Notes: pull-up modelled on irq line
`default_nettype none
interface hbp_if;
   logic csN;
   logic readStrobeN;
   logic writeStrobeN;
   logic addrLatchStrobeN;
   logic [2:0] addr;
   logic busStyleSel;
   logic muxBusEnable;
   logic resetPin;
   logic [7:0] hostData;
   logic hostDataOe;
   logic [7:0] devData;
   logic devDataOe;
   logic irqOut;
   logic irqOe;
   wire [7:0] dataBus = devDataOe ? devData : (hostDataOe ? hostData : 8'hff);
   wire irqLine = irqOe ? irqOut : 1'b1;
   modport device (input csN, readStrobeN, writeStrobeN, addrLatchStrobeN, addr, busStyleSel,
      muxBusEnable, resetPin, dataBus, output devData, devDataOe, irqOut, irqOe);
   modport host (output csN, readStrobeN, writeStrobeN, addrLatchStrobeN, addr, busStyleSel,
      muxBusEnable, resetPin, hostData, hostDataOe, input dataBus, irqLine);
endinterface
`default_nettype wire

// ### design/hbp_params.svh
// Purpose: Constants for the host bus port, both ends
// Assumes: 40 MHz clk; strobes taken as synchronous inputs
// Notes: Operation list below
// Operation
// - Separate-strobe mode: interrupt is active high
// - Separate-strobe interrupt driven only when enabled
// - Direction-select mode: interrupt open-drain active low
// - Reset polarity follows bus-style select
// - Reset held 40 ns clears everything but the sampled serial in bits
// - In reset: serial out high, inputs ignored
// - Mux enable overrides bus-style select
// - Mux address captured on latch strobe rise
// - Data phase after latch strobe high
// - Read strobe fall drives addressed byte
// - Write strobe rise stores data byte
// - Chip select starts access, strobe decides
// - Separate-strobe mode uses addr[2:1], with latch strobe pin as address bit 0
// - Direction mode: read strobe high, write is direction
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH
`define HBP_CLK_PERIOD_NS 25
`define HBP_RESET_MIN_NS 40
`define HBP_RESET_CYCLES ((`HBP_RESET_MIN_NS + `HBP_CLK_PERIOD_NS - 1) / `HBP_CLK_PERIOD_NS)
`define HBP_NUM_REGS 8
`define HBP_REG_RESET 8'h00
`define HBP_IRQ_OE_BIT 3
`define HBP_CTRL_REG 3'h4
`define HBP_STROBE_WAIT 4
`endif

// ### design/hbp_pkg.sv
// Purpose: Types for the host bus port
// Assumes: none
// Notes: shared by both ends
`default_nettype none
package hbp_pkg;
   typedef enum logic [1:0] {HBP_SEP_STROBE, HBP_DIR_SELECT, HBP_MUX_BUS} hbp_mode_t;
   typedef enum {HH_IDLE, HH_ADDR, HH_LATCH, HH_STROBE, HH_RELEASE, HH_DONE} hbp_host_state_t;
endpackage
`default_nettype wire

// ### design/hbp_sync.sv
// Purpose: Two-flop synchroniser with edge flags
// Assumes: single clock
// Notes: edges taken from second and third stages only
`default_nettype none
module hbp_sync
   import hbp_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_b, // Async reset
   input wire logic [3:0] din, // Raw inputs
   output logic [3:0] level, // Synchronised level
   output logic [3:0] rise, // Rising pulse
   output logic [3:0] fall // Falling pulse
);
   typedef struct packed {logic [3:0] s1; logic [3:0] s2; logic [3:0] s3;} hbp_sync_st_t;
   hbp_sync_st_t st_q, st_d;
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         st_q <= {12'hfff};
      else
         st_q <= st_d;
   end
   assign level = st_q.s2;
   assign rise = st_q.s2 & ~st_q.s3;
   assign fall = ~st_q.s2 & st_q.s3;
endmodule // hbp_sync
`default_nettype wire

// ### tb/hbp_assertions.sv
// Purpose: Pin-level checks between host and device ends
// Assumes: both ends on clk; modes decoded from the pins
// Notes: instantiated beside the interface in tb
`default_nettype none
module hbp_assertions (
   input wire logic clk, // Clock
   input wire logic rst_b, // Async reset
   input wire logic csN, // Chip select
   input wire logic readStrobeN, // Read strobe
   input wire logic writeStrobeN, // Write strobe or direction
   input wire logic addrLatchStrobeN, // Latch strobe
   input wire logic busStyleSel, // Bus style select
   input wire logic muxBusEnable, // Mux enable
   input wire logic resetPin, // Device reset pin
   input wire logic hostDataOe, // Host drives data
   input wire logic devDataOe, // Device drives data
   input wire logic irqOut, // Irq value
   input wire logic irqOe, // Irq drive enable
   input wire logic serialTx // Serial out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sepMode;
   logic dirMode;
   assign sepMode = !muxBusEnable && busStyleSel;
   assign dirMode = !muxBusEnable && !busStyleSel;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ****************************************
   // Assertions
   // ****************************************
   sequence sReadFall;
      $fell(readStrobeN) && !csN && !dirMode;
   endsequence
   sequence sPinReset;
      sepMode && resetPin;
   endsequence
   a_tx_held_high: assert property (serialTx)
      else $error("serial out left idle level");
   a_dir_irq_low: assert property (dirMode && irqOe |-> !irqOut)
      else $error("open drain irq drove high");
   a_dir_read_tied: assert property (dirMode && !csN |-> readStrobeN)
      else $error("read strobe used in direction mode");
   a_read_answer: assert property (sReadFall |-> ##[1:5] devDataOe)
      else $error("read data not driven");
   a_no_contention: assert property (!(devDataOe && hostDataOe))
      else $error("both ends drive data");
   a_idle_released: assert property (csN [*6] |-> !devDataOe)
      else $error("data driven while deselected");
   a_latch_addr_driven: assert property (muxBusEnable && !csN && !addrLatchStrobeN |-> hostDataOe)
      else $error("address not on lines at latch");
   a_write_data_driven: assert property (!dirMode && !csN && !writeStrobeN |-> hostDataOe)
      else $error("write data not driven");
   a_reset_irq_off: assert property (sPinReset |-> ##[1:4] !irqOe)
      else $error("irq driven after pin reset");
endmodule // hbp_assertions
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for both ends of the host bus port
// Assumes: host and device share clk
// Notes: register model kept as an int array
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      comparisons++; \
      if ((got) !== (ex)) \
      begin \
         errors++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb
   import hbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_b, resetReq, go, isWrite, busy, done, irqSeen, serialTx, serialRx, inReset, irqRequest;
   logic [1:0] modeSel;
   logic [1:0] modeOut;
   logic [2:0] regAddr;
   logic [7:0] wrData, rdData, rxSeen, held;
   int errors, comparisons, cycles, seed;
   int model[8];
   hbp_if busIf();
   hbp_host hbp_host_inst(.clk(clk), .rst_b(rst_b), .bus(busIf.host), .modeSel(modeSel), .resetReq(resetReq),
      .go(go), .isWrite(isWrite), .regAddr(regAddr), .wrData(wrData), .busy(busy), .done(done),
      .rdData(rdData), .irqSeen(irqSeen));
   hbp_device hbp_device_inst(.clk(clk), .rst_b(rst_b), .bus(busIf.device), .serialTx(serialTx),
      .serialRx(serialRx), .rxSeen(rxSeen), .inReset(inReset), .modeOut(modeOut), .irqRequest(irqRequest));
   hbp_assertions hbp_assertions_inst(.clk(clk), .rst_b(rst_b), .csN(busIf.csN),
      .readStrobeN(busIf.readStrobeN), .writeStrobeN(busIf.writeStrobeN),
      .addrLatchStrobeN(busIf.addrLatchStrobeN), .busStyleSel(busIf.busStyleSel),
      .muxBusEnable(busIf.muxBusEnable), .resetPin(busIf.resetPin), .hostDataOe(busIf.hostDataOe),
      .devDataOe(busIf.devDataOe), .irqOut(busIf.irqOut), .irqOe(busIf.irqOe), .serialTx(serialTx));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      #1;
      serialRx = 1'($random(seed));
   end
   initial
   begin
      wait (cycles == 5000);
      errors++;
      $display("ERROR timeout expected finish seen hang");
      wrap_up();
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      #1;
      go = 1'b1;
      isWrite = w;
      regAddr = a;
      wrData = d;
      @(posedge clk);
      #1;
      go = 1'b0;
      `CHK("busy", 1'b1, busy);
      n = 0;
      while (done !== 1'b1 && n < 60)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK("done", 1'b1, done);
      `CHK("busy", 1'b0, busy);
      if (w)
         model[a] = int'(d);
      else
         `CHK("rdData", 8'(model[a]), rdData);
   endtask
   task automatic pin_reset();
      int n;
      @(posedge clk);
      #1;
      resetReq = 1'b1;
      @(posedge clk);
      #1;
      resetReq = 1'b0;
      n = 0;
      while (inReset !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      held = rxSeen;
      @(posedge clk);
      #1;
      `CHK("inReset", 1'b1, inReset);
      `CHK("rxSeen", held, rxSeen);
      `CHK("serialTx", 1'b1, serialTx);
      repeat (8) @(posedge clk);
      foreach (model[i]) model[i] = 0;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      errors = 0;
      comparisons = 0;
      cycles = 0;
      seed = 176;
      rst_b = 1'b0;
      {resetReq, go, isWrite, irqRequest} = '0;
      regAddr = 3'h0;
      wrData = 8'h00;
      modeSel = HBP_SEP_STROBE;
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      for (int m = 0; m < 3; m++)
      begin
         modeSel = 2'(m);
         pin_reset();
         `CHK("modeOut", 2'(m), modeOut);
         for (int i = 0; i < 8; i++) acc(1'b1, 3'(i), 8'($random(seed)));
         for (int i = 7; i >= 0; i--) acc(1'b0, 3'(i), 8'h00);
         pin_reset();
         for (int i = 0; i < 8; i++) acc(1'b0, 3'(i), 8'h00);
         for (int k = 0; k < 4; k++)
         begin
            acc(1'b1, 3'h4, k[1] ? 8'h08 : 8'h00);
            irqRequest = !k[0];
            repeat (6) @(posedge clk);
            #1;
            `CHK("irqSeen", (m == 1) ? k[0] : (k[1] ? !k[0] : 1'b1), irqSeen);
         end
         $display("mode %0d test done", m);
      end
      wrap_up();
   end
endmodule // tb
`default_nettype wire
